// ==== design/twm_fifo.sv ====
// Small receive FIFO with valid and ready on both sides
`timescale 1ns/10ps
module twm_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // Clock and reset
    input wire logic    sys_clk,
    input wire logic    resetn,
    // Stream
    twm_fifo_if.store   q
);
    import twm_pkg::*;
    localparam int AW = $clog2(D);

    generate
        if (D < 2 || (1 << AW) != D || W < 1) begin : g_bad
            $error("twm_fifo depth must be a power of two of at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } twm_fifo_st_t;

    twm_fifo_st_t r;
    twm_fifo_st_t next_r;
    logic         push;
    logic         pop;

    assign q.in_ready  = (r.cnt != (AW+1)'(D));
    assign q.out_valid = (r.cnt != '0);
    assign q.out_data  = r.mem[r.rp];

    always_comb begin
        next_r = r;
        push   = q.in_valid && q.in_ready;
        pop    = q.out_valid && q.out_ready;
        if (push) begin
            next_r.mem[r.wp] = q.in_data;
            next_r.wp        = r.wp + 1'b1;
        end
        if (pop) begin
            next_r.rp = r.rp + 1'b1;
        end
        next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    a_fifo_bound: assert property (@(posedge sys_clk) disable iff (!resetn)
        r.cnt <= (AW+1)'(D)) else $error("fifo count over depth");
    a_fifo_count: assert property (@(posedge sys_clk) disable iff (!resetn)
        push && !pop |=> r.cnt == $past(r.cnt) + 1'b1)
        else $error("fifo count wrong");
endmodule // twm_fifo

// ==== design/twm_fifo_if.sv ====
// Byte stream between the bus engine and the receive FIFO
`timescale 1ns/10ps
interface twm_fifo_if #(parameter int W = 8);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport fill  (output in_valid, output in_data, input in_ready,
                   input out_valid, input out_data, output out_ready);
    modport store (input in_valid, input in_data, output in_ready,
                   output out_valid, output out_data, input out_ready);
endinterface

// ==== design/twm_master.sv ====
// Two-wire serial bus master with combined write and read transfers
`timescale 1ns/10ps
module twm_master (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Command
    input  wire logic       cmd_start,
    input  wire logic       cmd_fast,
    input  wire logic [6:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    input  wire logic [7:0] cmd_rcnt,
    // Status
    output logic            busy,
    output logic            done,
    output logic            nack,
    // Received bytes
    output logic [twm_pkg::BYTE_W-1:0] rd_data,
    output logic            rd_valid,
    input  wire logic       rd_ready,
    // Bus pins
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe
);
    import twm_pkg::*;

    typedef struct packed {
        twm_state_t  st;
        twm_stage_t  stage;
        logic [1:0]  phase;
        logic [7:0]  cnt;
        logic [3:0]  bitn;
        logic [7:0]  shreg;
        logic [6:0]  addr;
        logic [7:0]  wdata;
        logic [7:0]  rleft;
        logic        fast;
        logic        scl_low;
        logic        sda_low;
        logic        nack;
        logic        done;
        logic [1:0]  scl_s;
        logic [1:0]  sda_s;
    } twm_st_t;

    twm_st_t    r;
    twm_st_t    next_r;
    logic [7:0] qlen;
    logic       step;
    logic       wait_scl;
    logic       push;
    logic       push_vld;

    twm_fifo_if #(.W(BYTE_W)) fq ();

    twm_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .q       (fq)
    );

    assign fq.in_valid  = push_vld;
    assign fq.in_data   = r.shreg;
    assign fq.out_ready = rd_ready;
    assign rd_data      = fq.out_data;
    assign rd_valid     = fq.out_valid;
    assign busy         = (r.st != ST_IDLE);
    assign done         = r.done;
    assign nack         = r.nack;
    // Open drain: output data is always low, only the enable moves
    assign scl_out      = 1'b0;
    assign sda_out      = 1'b0;
    assign scl_oe       = r.scl_low;
    assign sda_oe       = r.sda_low;

    always_comb begin
        next_r       = r;
        next_r.done  = 1'b0;
        next_r.scl_s = {r.scl_s[0], scl_in};
        next_r.sda_s = {r.sda_s[0], sda_in};
        qlen     = r.fast ? QTR_FAST : QTR_STD;
        step     = (r.cnt == qlen - 8'h01);
        // Slave may stretch the clock; a data bit's high phase waits for SCL high
        wait_scl = (r.st == ST_BIT) && (r.phase == 2'h2) && !r.scl_s[1];
        push     = (r.st == ST_BIT) && (r.stage == SG_READ) &&
                   (r.bitn == ACK_BIT) && (r.phase == 2'h0);
        push_vld = push && step;
        if (r.st == ST_IDLE) begin
            next_r.cnt   = 8'h00;
            next_r.phase = 2'h0;
            if (cmd_start) begin
                next_r.st    = ST_START;
                next_r.stage = SG_ADDRW;
                next_r.fast  = cmd_fast;
                next_r.addr  = cmd_addr;
                next_r.wdata = cmd_wdata;
                next_r.rleft = cmd_rcnt;
                next_r.shreg = {cmd_addr, WR_BIT};
                next_r.nack  = 1'b0;
            end
        end else if (!step || wait_scl) begin
            next_r.cnt = step ? r.cnt : r.cnt + 8'h01;
        end else if (push && !fq.in_ready) begin
            // FIFO full: hold SCL low until space frees
            next_r.cnt = r.cnt;
        end else begin
            next_r.cnt   = 8'h00;
            next_r.phase = r.phase + 2'h1;
            case (r.st)
                ST_START: begin
                    if (r.phase == 2'h0) begin
                        next_r.sda_low = 1'b1;
                    end else if (r.phase == 2'h1) begin
                        next_r.scl_low = 1'b1;
                    end else begin
                        next_r.st    = ST_BIT;
                        next_r.phase = 2'h0;
                        next_r.bitn  = 4'h0;
                    end
                end
                ST_BIT: begin
                    case (r.phase)
                        2'h0: begin
                            // SDA moves only while SCL is low
                            if (r.bitn != ACK_BIT) begin
                                next_r.sda_low = (r.stage != SG_READ) &&
                                                 !r.shreg[7];
                            end else begin
                                next_r.sda_low = (r.stage == SG_READ) &&
                                                 (r.rleft > 8'h01);
                            end
                        end
                        2'h1: next_r.scl_low = 1'b0;
                        2'h2: begin
                            // Sample once SCL has been seen high
                            if (r.bitn != ACK_BIT) begin
                                next_r.shreg = {r.shreg[6:0],
                                    (r.stage == SG_READ) & r.sda_s[1]};
                            end else if (r.stage != SG_READ) begin
                                next_r.nack = r.sda_s[1];
                            end
                        end
                        default: begin
                            next_r.scl_low = 1'b1;
                            if (r.bitn != ACK_BIT) begin
                                next_r.bitn = r.bitn + 4'h1;
                            end else begin
                                next_r.bitn = 4'h0;
                                case (r.stage)
                                    SG_ADDRW: begin
                                        if (r.sda_low || !r.nack) begin
                                            next_r.stage = SG_DATA;
                                            next_r.shreg = r.wdata;
                                        end else begin
                                            next_r.st = ST_STOP;
                                        end
                                    end
                                    SG_DATA: begin
                                        if (r.nack || r.rleft == 8'h00) begin
                                            next_r.st = ST_STOP;
                                        end else begin
                                            next_r.st = ST_RSTART;
                                        end
                                    end
                                    SG_ADDRR: begin
                                        if (r.nack) begin
                                            next_r.st = ST_STOP;
                                        end else begin
                                            next_r.stage = SG_READ;
                                        end
                                    end
                                    default: begin
                                        next_r.rleft = r.rleft - 8'h01;
                                        if (r.rleft == 8'h01) begin
                                            next_r.st = ST_STOP;
                                        end
                                    end
                                endcase
                            end
                        end
                    endcase
                end
                ST_RSTART: begin
                    case (r.phase)
                        2'h0: next_r.sda_low = 1'b0;
                        2'h1: next_r.scl_low = 1'b0;
                        2'h2: next_r.sda_low = 1'b1;
                        default: begin
                            next_r.scl_low = 1'b1;
                            next_r.st      = ST_BIT;
                            next_r.stage   = SG_ADDRR;
                            next_r.shreg   = {r.addr, RD_BIT};
                            next_r.bitn    = 4'h0;
                        end
                    endcase
                end
                ST_STOP: begin
                    case (r.phase)
                        2'h0: next_r.sda_low = 1'b1;
                        2'h1: next_r.scl_low = 1'b0;
                        2'h2: next_r.sda_low = 1'b0;
                        default: begin
                            next_r.st   = ST_IDLE;
                            next_r.done = 1'b1;
                        end
                    endcase
                end
                default: next_r.st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    a_eight_bits: assert property (@(posedge sys_clk) disable iff (!resetn)
        r.bitn <= ACK_BIT) else $error("bit index past ack slot");
    a_msb_first: assert property (@(posedge sys_clk) disable iff (!resetn)
        r.st == ST_BIT && r.phase == 2'h1 && r.bitn != ACK_BIT &&
        r.stage != SG_READ && $changed(r.phase) |-> sda_oe == !r.shreg[7])
        else $error("sent bit is not the top bit");
    a_sda_stable: assert property (@(posedge sys_clk) disable iff (!resetn)
        r.st == ST_BIT && !scl_oe && $past(!scl_oe) |-> $stable(sda_oe))
        else $error("sda moved while scl high");
    a_read_ack: assert property (@(posedge sys_clk) disable iff (!resetn)
        r.st == ST_BIT && r.stage == SG_READ && r.bitn == ACK_BIT &&
        r.phase == 2'h2 |-> sda_oe == (r.rleft > 8'h01))
        else $error("read acknowledge wrong");
    a_start_cond: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(r.st == ST_START) |-> ##1 !sda_oe ##[1:200] sda_oe && !scl_oe)
        else $error("start condition malformed");
    a_push_stall: assert property (@(posedge sys_clk) disable iff (!resetn)
        push_vld && !fq.in_ready |=> scl_oe && r.phase == 2'h0)
        else $error("full fifo did not hold scl low");
    a_rstart_src: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(r.st == ST_RSTART) |-> $past(r.stage) == SG_DATA &&
        r.rleft != 8'h00) else $error("repeated start out of order");
    a_quarter_len: assert property (@(posedge sys_clk) disable iff (!resetn)
        busy |-> r.cnt < (r.fast ? QTR_FAST : QTR_STD))
        else $error("quarter counter over its rate");
    a_open_drain: assert property (@(posedge sys_clk) disable iff (!resetn)
        !scl_out && !sda_out && (busy || (!scl_oe && !sda_oe)))
        else $error("pin driven high or line held while idle");
    a_ack_slot: assert property (@(posedge sys_clk) disable iff (!resetn)
        r.st == ST_BIT && r.stage != SG_READ && r.bitn == ACK_BIT &&
        r.phase == 2'h1 |-> !sda_oe) else $error("master drove slave ack");
    a_sample_high: assert property (@(posedge sys_clk) disable iff (!resetn)
        r.st == ST_BIT && r.phase == 2'h3 |-> !scl_oe && $past(r.scl_s[1]))
        else $error("sampled with scl low");
endmodule // twm_master

// ==== design/twm_pkg.sv ====
// Constants and types for the two-wire serial master
package twm_pkg;
    localparam int SYS_HZ  = 50_000_000;
    localparam int STD_HZ  = 100_000;
    localparam int FAST_HZ = 400_000;
    // Quarter of an SCL period in clocks, rounded up so the rate never exceeds
    localparam logic [7:0] QTR_STD  =
        8'((SYS_HZ + 4 * STD_HZ - 1) / (4 * STD_HZ));
    localparam logic [7:0] QTR_FAST =
        8'((SYS_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ));
    localparam int         BYTE_W     = 8;
    localparam int         FIFO_DEPTH = 4;
    localparam logic [3:0] ACK_BIT    = 4'h8;
    localparam logic       WR_BIT     = 1'b0;
    localparam logic       RD_BIT     = 1'b1;
    localparam logic [1:0] PH_LAST    = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_BIT, ST_RSTART, ST_STOP
    } twm_state_t;

    typedef enum logic [1:0] {
        SG_ADDRW, SG_DATA, SG_ADDRR, SG_READ
    } twm_stage_t;
endpackage

// ==== tb/tb.sv ====
// Self-checking bench for the two-wire serial master
`timescale 1ns/10ps
module tb;
    import twm_pkg::*;
    localparam logic [6:0] SADDR = 7'h5A;
    localparam logic [7:0] BASE  = 8'hC3;
    logic       sys_clk = 1'b0, resetn = 1'b0, cmd_start = 1'b0;
    logic       cmd_fast = 1'b0, rd_ready = 1'b0, clr = 1'b0;
    logic [6:0] cmd_addr = 7'h00;
    logic [7:0] cmd_wdata = 8'h00, cmd_rcnt = 8'h00, stretch = 8'h00;
    logic       busy, done, nack, rd_valid, scl_out, scl_oe, sda_out, sda_oe;
    logic       s_scl_oe, s_sda_oe;
    logic [7:0] rd_data;
    logic [7:0] rxq[$];
    int         failures, tests_run, cyc;
    wire logic  scl_w = (scl_oe ? scl_out : 1'b1) & !s_scl_oe;
    wire logic  sda_w = (sda_oe ? sda_out : 1'b1) & !s_sda_oe;

    always #10 sys_clk = ~sys_clk;

    twm_master dut (.sys_clk(sys_clk), .resetn(resetn),
        .cmd_start(cmd_start), .cmd_fast(cmd_fast), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_rcnt(cmd_rcnt), .busy(busy),
        .done(done), .nack(nack), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
    twm_slave_model slv (.sys_clk(sys_clk), .resetn(resetn), .scl(scl_w),
        .sda(sda_w), .addr(SADDR), .base(BASE), .stretch(stretch),
        .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .clr(clr));

    always @(posedge sys_clk) if (rd_valid && rd_ready) rxq.push_back(rd_data);
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 90000) begin
            failures++;
            results();
        end
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic results;
        if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic go(logic f, logic [6:0] a, logic [7:0] w, r, int n);
        rxq.delete();
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        cmd_fast <= f;
        cmd_addr <= a;
        cmd_wdata <= w;
        cmd_rcnt <= r;
        cmd_start <= 1'b1;
        repeat (n) @(posedge sys_clk);
        cmd_start <= 1'b0;
    endtask

    task automatic wait_done;
        do @(negedge sys_clk); while (done !== 1'b1);
    endtask

    task automatic t_write;
        go(1'b0, SADDR, 8'hA5, 8'h00, 3);
        wait_done();
        check("addr byte", slv.got_addr, {SADDR, WR_BIT});
        check("write byte", slv.got_wdata, 8'hA5);
        check("starts", slv.starts, 1);
        check("stops", slv.stops, 1);
        check("nack", nack, 1'b0);
        check("std period", slv.per >= 4 * QTR_STD
              && slv.per <= 4 * QTR_STD + 6, 1'b1);
        check("pins low only", {scl_out, sda_out}, 2'h0);
    endtask

    task automatic t_read;
        @(posedge sys_clk);
        stretch <= 8'h50;
        rd_ready <= 1'b1;
        go(1'b1, SADDR, 8'h3C, 8'h03, 1);
        repeat (300) @(posedge sys_clk);
        cmd_start <= 1'b1;
        cmd_addr <= 7'h11;
        @(posedge sys_clk);
        cmd_start <= 1'b0;
        wait_done();
        repeat (20) @(negedge sys_clk);
        check("busy after", busy, 1'b0);
        check("read addr", slv.got_addr, {SADDR, RD_BIT});
        check("written", slv.got_wdata, 8'h3C);
        check("starts", slv.starts, 2);
        check("stops", slv.stops, 1);
        check("master acks", slv.macks, 2);
        check("master nacks", slv.mnaks, 1);
        check("count", rxq.size(), 3);
        foreach (rxq[i]) check("read byte", rxq[i], BASE + 8'(i));
        stretch <= 8'h00;
    endtask

    task automatic t_full;
        @(posedge sys_clk);
        rd_ready <= 1'b0;
        go(1'b1, SADDR, 8'h00, 8'h06, 1);
        repeat (12000) @(negedge sys_clk);
        check("stalled busy", busy, 1'b1);
        check("held", rd_valid, 1'b1);
        check("acks at stall", slv.macks, 4);
        check("fast period", slv.per >= 4 * QTR_FAST
              && slv.per <= 4 * QTR_FAST + 6, 1'b1);
        @(posedge sys_clk);
        rd_ready <= 1'b1;
        wait_done();
        repeat (6) @(negedge sys_clk);
        check("count", rxq.size(), 6);
        foreach (rxq[i]) check("read byte", rxq[i], BASE + 8'(i));
        check("master nacks", slv.mnaks, 1);
    endtask

    task automatic t_nack;
        go(1'b1, 7'h21, 8'h55, 8'h02, 1);
        wait_done();
        check("nack", nack, 1'b1);
        check("starts", slv.starts, 1);
        check("stops", slv.stops, 1);
        check("none read", rxq.size(), 0);
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        t_write();
        t_read();
        t_full();
        t_nack();
        results();
    end
endmodule // tb

// ==== tb/twm_slave_model.sv ====
// Behavioural two-wire slave that answers the master on the bus
`timescale 1ns/10ps
module twm_slave_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Resolved bus lines
    input  wire logic       scl,
    input  wire logic       sda,
    // Behaviour
    input  wire logic [6:0] addr,
    input  wire logic [7:0] base,
    input  wire logic [7:0] stretch,
    input  wire logic       clr,
    // Line pull-downs
    output logic            scl_oe,
    output logic            sda_oe
);
    logic       pscl, psda, ack, first, on, tx, nxt_tx, go;
    logic [7:0] sh, txb, hold, got_addr, got_wdata;
    int         cnt, tcnt, per, starts, stops, macks, mnaks;

    // Low phase stretched after every falling clock edge from a start until a stop or an address mismatch
    assign scl_oe = (hold != 8'h00);

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pscl = 1'b1;
            psda = 1'b1;
            on = 1'b0;
            sda_oe <= 1'b0;
            hold <= 8'h00;
        end else begin
            tcnt++;
            // Event counters restart for each scenario
            if (clr) begin
                starts = 0;
                stops = 0;
                macks = 0;
                mnaks = 0;
            end
            if (hold != 8'h00) hold <= hold - 8'h01;
            if (scl && pscl && psda && !sda) begin
                starts++;
                cnt = 0;
                ack = 1'b0;
                first = 1'b1;
                on = 1'b1;
                tx = 1'b0;
                nxt_tx = 1'b0;
                sda_oe <= 1'b0;
            end else if (scl && pscl && !psda && sda) begin
                stops++;
                on = 1'b0;
                sda_oe <= 1'b0;
            end else if (on && scl && !pscl) begin
                if (ack) begin
                    if (tx && !sda) begin
                        macks++;
                        txb = txb + 8'h01;
                    end else if (tx) begin
                        mnaks++;
                        go = 1'b0;
                    end
                end else begin
                    if (cnt != 0) per = tcnt;
                    sh = {sh[6:0], sda};
                    cnt++;
                end
                tcnt = 0;
            end else if (on && !scl && pscl) begin
                hold <= stretch;
                if (ack) begin
                    ack = 1'b0;
                    cnt = 0;
                    tx = nxt_tx;
                    sda_oe <= nxt_tx && go && !txb[7];
                end else if (cnt == 8) begin
                    ack = 1'b1;
                    if (first) begin
                        first = 1'b0;
                        got_addr = sh;
                        on = (sh[7:1] == addr);
                        nxt_tx = sh[0];
                        go = 1'b1;
                        txb = base;
                        sda_oe <= (sh[7:1] == addr);
                    end else if (tx) sda_oe <= 1'b0;
                    else begin
                        got_wdata = sh;
                        sda_oe <= 1'b1;
                    end
                end else if (tx) sda_oe <= !txb[7-cnt];
            end
            pscl = scl;
            psda = sda;
        end
    end
endmodule // twm_slave_model
